// ===== mio_pkg.sv
// Shared constants and types for the multiplexed port unit
package mio_pkg;
   // Register map: one 16-byte group per port
   localparam int APB_DW = 32;
   localparam int PORT_COUNT = 3;
   localparam logic [1:0] REG_FUNC_SEL = 2'h0;
   localparam logic [1:0] REG_DIR = 2'h1;
   localparam logic [1:0] REG_LATCH = 2'h2;
   localparam logic [1:0] REG_LEVEL = 2'h3;
   localparam int REG_SEL_LSB = 2;
   localparam int PORT_SEL_LSB = 4;
   localparam int MAP_TOP_BIT = 6;
   localparam logic [1:0] PORT_NONE = 2'h3;
   // Implemented bits of each port
   localparam logic [7:0] P1_MASK = 8'hFF;
   localparam logic [7:0] P2_MASK = 8'hFF;
   localparam logic [7:0] P3_MASK = 8'h3F;
   // Values after reset
   localparam logic [7:0] P1_FUNC_RST = 8'hFF;
   localparam logic [7:0] P2_FUNC_RST = 8'hFF;
   localparam logic [7:0] P3_FUNC_RST = 8'h0F;
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [APB_DW-1:0] RDATA_RST = 32'h0000_0000;
   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

   typedef enum {
      MIO_BIDIR,
      MIO_OUT_ONLY,
      MIO_OPEN_DRAIN
   } mio_kind_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } mio_pad8_t;

   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe;
   } mio_pad6_t;

   function automatic logic [7:0] mio_port_mask(input logic [1:0] port);
      case (port)
         2'h0: mio_port_mask = P1_MASK;
         2'h1: mio_port_mask = P2_MASK;
         2'h2: mio_port_mask = P3_MASK;
         default: mio_port_mask = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] mio_func_rst(input logic [1:0] port);
      case (port)
         2'h0: mio_func_rst = P1_FUNC_RST;
         2'h1: mio_func_rst = P2_FUNC_RST;
         2'h2: mio_func_rst = P3_FUNC_RST;
         default: mio_func_rst = 8'h00;
      endcase
   endfunction
endpackage

// ===== mio_pin_cell.sv
// One port pin: synchroniser, source multiplexer and registered drive
`timescale 1ns/100ps
module mio_pin_cell #(
   parameter mio_pkg::mio_kind_t KIND = mio_pkg::MIO_BIDIR
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control from the register file
   input wire logic sel_periph,
   input wire logic dir,
   input wire logic latch,
   // Peripheral side
   input wire logic periph_out,
   input wire logic periph_oe,
   // Pad side
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic level
);
   localparam logic OE_RST = (KIND == mio_pkg::MIO_OUT_ONLY) ? 1'b1 : 1'b0;

   logic sync_first;
   logic next_out;
   logic next_oe;

   // Pad level passes two flops; only the second one is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_first <= 1'b0;
         level <= 1'b0;
      end else begin
         sync_first <= pad_in; // [R6] [R21]
         level <= sync_first; // [R6] [R21]
      end
   end

   always_comb begin
      next_out = 1'b0;
      next_oe = 1'b0;
      case (KIND)
         mio_pkg::MIO_BIDIR: begin
            next_out = sel_periph ? periph_out : latch;
            next_oe = sel_periph ? periph_oe : !dir;
         end
         mio_pkg::MIO_OUT_ONLY: begin
            next_out = sel_periph ? periph_out : latch;
            next_oe = 1'b1;
         end
         mio_pkg::MIO_OPEN_DRAIN: begin
            // Only ever pulls low; peripheral choice floats the pin
            next_out = 1'b0;
            next_oe = !sel_periph && !dir && !latch; // [R10] [R11] [R12]
         end
         default: begin
            next_out = 1'b0;
            next_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out <= 1'b0;
         pad_oe <= OE_RST;
      end else begin
         pad_out <= next_out;
         pad_oe <= next_oe;
      end
   end
endmodule // mio_pin_cell

// ===== mio_port_unit.sv
// APB register file and pin multiplexing for three ports
//
// Notes on behaviour
// (R1) Per-pin select: peripheral or port registers
// (R2) Bidir peripheral mode: peripheral drives data, direction
// (R3) Bidir port mode: direction clear drives pin
// (R4) Bidir port mode: direction set floats pin
// (R5) Port output value comes from latch
// (R6) Pin level synchronised before being read
// (R7) Pin level readable in every mode
// (R8) Output-only pins always driven, source selectable
// (R9) Output-only direction bit is plain storage
// (R10) Open-drain: latch zero pulls low, one floats
// (R11) Open-drain: direction set floats pin
// (R12) Open-drain peripheral choice floats pin
// (R13) Port one: eight outputs with chip selects
// (R14) Port two: eight bidir pins, two serials
// (R15) Port three: four outputs, two open-drain
// (R16) Four registers per port
// (R17) Direction resets to ones, reads back written
// (R18) Latch read returns latch, not pins
// (R19) Reset modes: peripherals, open-drain floating
// (R20) Software loads latch before choosing output
// (R21) Two-flop synchroniser feeds pin level register
// (R22) Unimplemented bits read zero, ignore writes
`timescale 1ns/100ps
module mio_port_unit #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chip-select and interrupt request sources
   input wire logic [7:0] general_chip_selects,
   input wire logic dma0_irq_out,
   input wire logic dma1_irq_out,
   input wire logic serial1_tx_irq_out,
   input wire logic serial1_rx_irq_out,
   // Serial channel sources
   input wire logic serial0_transmit,
   input wire logic serial1_transmit,
   input wire logic serial0_receive_out,
   input wire logic serial0_receive_oe,
   input wire logic serial1_receive_out,
   input wire logic serial1_receive_oe,
   // Serial channel pin levels
   output logic serial0_receive,
   output logic serial0_baud_clock_in,
   output logic serial0_clear_to_send,
   output logic serial1_receive,
   output logic serial1_baud_clock_in,
   output logic serial1_clear_to_send,
   // Pads
   input wire logic [7:0] p1_pad_in,
   output mio_pkg::mio_pad8_t p1_pad,
   input wire logic [7:0] p2_pad_in,
   output mio_pkg::mio_pad8_t p2_pad,
   input wire logic [5:0] p3_pad_in,
   output mio_pkg::mio_pad6_t p3_pad
);
   // Refuse an address bus too narrow for the map
   if (ADDR_W < mio_pkg::MAP_TOP_BIT) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end


   logic [7:0] func_sel [0:2];
   logic [7:0] dir_bits [0:2];
   logic [7:0] out_latch [0:2];
   logic [7:0] level [0:2];
   logic [7:0] p2_per_out;
   logic [7:0] p2_per_oe;
   logic [3:0] p3_per_out;
   logic [1:0] acc_port;
   logic [1:0] acc_reg;
   logic acc_hit;
   logic wr_take;
   logic [7:0] next_rdata;

   // Address decode
   assign acc_port = paddr[mio_pkg::PORT_SEL_LSB +: 2];
   assign acc_reg = paddr[mio_pkg::REG_SEL_LSB +: 2];
   assign acc_hit = (acc_port != mio_pkg::PORT_NONE) && (paddr[1:0] == 2'h0)
      && ((paddr >> mio_pkg::MAP_TOP_BIT) == '0);
   assign wr_take = psel && penable && pwrite && pready && acc_hit && pstrb[0];

   // Register file; each port keeps its own mask
   for (genvar k = 0; k < mio_pkg::PORT_COUNT; k++) begin : g_regs
      localparam logic [1:0] PK = 2'(k);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            func_sel[k] <= mio_pkg::mio_func_rst(PK); // [R19]
            dir_bits[k] <= mio_pkg::DIR_RST & mio_pkg::mio_port_mask(PK); // [R17]
            out_latch[k] <= mio_pkg::LATCH_RST & mio_pkg::mio_port_mask(PK);
         end else if (wr_take && acc_port == PK) begin
            case (acc_reg)
               mio_pkg::REG_FUNC_SEL: begin
                  func_sel[k] <= pwdata[7:0] & mio_pkg::mio_port_mask(PK); // [R1] [R22]
               end
               mio_pkg::REG_DIR: begin
                  dir_bits[k] <= pwdata[7:0] & mio_pkg::mio_port_mask(PK); // [R9] [R17]
               end
               mio_pkg::REG_LATCH: begin
                  out_latch[k] <= pwdata[7:0] & mio_pkg::mio_port_mask(PK); // [R5]
               end
               default: begin
                  // Pin level register is read-only
               end
            endcase
         end
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 8'h00;
      if (acc_hit) begin
         case (acc_reg)
            mio_pkg::REG_FUNC_SEL: next_rdata = func_sel[acc_port]; // [R16]
            mio_pkg::REG_DIR: next_rdata = dir_bits[acc_port]; // [R17]
            mio_pkg::REG_LATCH: next_rdata = out_latch[acc_port]; // [R18]
            mio_pkg::REG_LEVEL: begin
               next_rdata = level[acc_port] & mio_pkg::mio_port_mask(acc_port); // [R7] [R21]
            end
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Answer is prepared in the setup cycle, so no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= mio_pkg::RDATA_RST;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= {24'h000000, next_rdata}; // [R22]
         pslverr <= !acc_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
      end
   end

   // Port one: chip selects on output-only pins
   for (genvar i = 0; i < 8; i++) begin : g_p1
      mio_pin_cell #(.KIND(mio_pkg::MIO_OUT_ONLY)) u_cell ( // [R13] [R8]
         .clk(pclk),
         .rst_n(presetn),
         .sel_periph(func_sel[0][i]),
         .dir(dir_bits[0][i]),
         .latch(out_latch[0][i]),
         .periph_out(general_chip_selects[i]),
         .periph_oe(1'b1),
         .pad_in(p1_pad_in[i]),
         .pad_out(p1_pad.out[i]),
         .pad_oe(p1_pad.oe[i]),
         .level(level[0][i])
      );
   end

   // Port two: serial channel pins in bit order rx, tx, baud, cts
   assign p2_per_out = {2'b00, serial1_transmit, serial1_receive_out,
      2'b00, serial0_transmit, serial0_receive_out}; // [R14]
   assign p2_per_oe = {2'b00, 1'b1, serial1_receive_oe,
      2'b00, 1'b1, serial0_receive_oe}; // [R14]

   for (genvar i = 0; i < 8; i++) begin : g_p2
      mio_pin_cell #(.KIND(mio_pkg::MIO_BIDIR)) u_cell ( // [R2] [R3] [R4]
         .clk(pclk),
         .rst_n(presetn),
         .sel_periph(func_sel[1][i]),
         .dir(dir_bits[1][i]),
         .latch(out_latch[1][i]),
         .periph_out(p2_per_out[i]),
         .periph_oe(p2_per_oe[i]),
         .pad_in(p2_pad_in[i]),
         .pad_out(p2_pad.out[i]),
         .pad_oe(p2_pad.oe[i]),
         .level(level[1][i])
      );
   end

   assign serial0_receive = level[1][0];
   assign serial0_baud_clock_in = level[1][2];
   assign serial0_clear_to_send = level[1][3];
   assign serial1_receive = level[1][4];
   assign serial1_baud_clock_in = level[1][6];
   assign serial1_clear_to_send = level[1][7];

   // Port three: interrupt requests, then two open-drain pins
   assign p3_per_out = {dma1_irq_out, dma0_irq_out, serial1_tx_irq_out, serial1_rx_irq_out};

   for (genvar i = 0; i < 6; i++) begin : g_p3
      localparam mio_pkg::mio_kind_t PKIND = (i < 4) ? mio_pkg::MIO_OUT_ONLY
         : mio_pkg::MIO_OPEN_DRAIN;
      mio_pin_cell #(.KIND(PKIND)) u_cell ( // [R15] [R10] [R11] [R12]
         .clk(pclk),
         .rst_n(presetn),
         .sel_periph(func_sel[2][i]),
         .dir(dir_bits[2][i]),
         .latch(out_latch[2][i]),
         .periph_out((i < 4) ? p3_per_out[i % 4] : 1'b0),
         .periph_oe(1'b1),
         .pad_in(p3_pad_in[i]),
         .pad_out(p3_pad.out[i]),
         .pad_oe(p3_pad.oe[i]),
         .level(level[2][i])
      );
   end
   assign level[2][7:6] = 2'b00;

   // Cycles since reset release, for checks that look back
   logic [1:0] settle;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle <= 2'h0;
      end else if (settle != 2'h3) begin
         settle <= settle + 2'h1;
      end
   end

   a_p1_always_driven: assert property ( // [R8]
      @(posedge pclk) disable iff (!presetn) p1_pad.oe == 8'hFF && p3_pad.oe[3:0] == 4'hF)
      else $error("output-only pin not driven");

   a_p1_source_mux: assert property ( // [R1] [R13]
      @(posedge pclk) disable iff (!presetn) (settle != 2'h0) |->
      p1_pad.out == (($past(func_sel[0]) & $past(general_chip_selects))
         | (~$past(func_sel[0]) & $past(out_latch[0]))))
      else $error("port one data source wrong");

   a_p2_dir_control: assert property ( // [R2] [R3] [R4]
      @(posedge pclk) disable iff (!presetn) (settle != 2'h0) |->
      p2_pad.oe == (($past(func_sel[1]) & $past(p2_per_oe))
         | (~$past(func_sel[1]) & ~$past(dir_bits[1]))))
      else $error("port two driver enable wrong");

   a_p2_port_data: assert property ( // [R5]
      @(posedge pclk) disable iff (!presetn)
      (settle != 2'h0) && $past(func_sel[1][5]) == 1'b0 |->
      p2_pad.out[5] == $past(out_latch[1][5]))
      else $error("port two data not from latch");

   a_od_pull_down: assert property ( // [R10] [R11] [R12]
      @(posedge pclk) disable iff (!presetn) (settle != 2'h0) |->
      p3_pad.out[5:4] == 2'b00 && p3_pad.oe[5:4] ==
      (~$past(func_sel[2][5:4]) & ~$past(dir_bits[2][5:4]) & ~$past(out_latch[2][5:4])))
      else $error("open-drain drive wrong");

   a_sync_two_stage: assert property ( // [R6] [R21]
      @(posedge pclk) disable iff (!presetn) (settle == 2'h3) |->
      level[1] == $past(p2_pad_in, 2) && level[2][5:0] == $past(p3_pad_in, 2))
      else $error("synchroniser depth wrong");

   a_dir_readback: assert property ( // [R17] [R9]
      @(posedge pclk) disable iff (!presetn)
      wr_take && acc_reg == mio_pkg::REG_DIR && acc_port == 2'h0 |=>
      dir_bits[0] == $past(pwdata[7:0]))
      else $error("direction write not stored");

   a_unused_read_zero: assert property ( // [R22]
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready |-> prdata[31:8] == 24'h000000
      && (!(prdata[7:6] != 2'b00) || $past(acc_port) != 2'h2))
      else $error("unused bits not zero");

   a_reset_modes: assert property ( // [R19]
      @(posedge pclk) (settle == 2'h1) |->
      p3_pad.oe[5:4] == 2'b00 && p2_pad.oe == $past(p2_per_oe))
      else $error("reset mode wrong");
endmodule // mio_port_unit

// ===== mio_pins_model.sv
// Package pins around the port unit with far-side drivers and pull-ups
`timescale 1ns/100ps
module mio_pins_model (
   // Pads from the unit
   input wire mio_pkg::mio_pad8_t p1_pad,
   input wire mio_pkg::mio_pad8_t p2_pad,
   input wire mio_pkg::mio_pad6_t p3_pad,
   // Far-side level where the unit does not drive
   input wire logic [7:0] ext_p2,
   input wire logic [5:0] ext_p3,
   // Resolved pin levels
   output logic [7:0] p1_pad_in,
   output logic [7:0] p2_pad_in,
   output logic [5:0] p3_pad_in
);
   always_comb begin
      p1_pad_in = (p1_pad.oe & p1_pad.out) | (~p1_pad.oe & ~p1_pad.out);
      p2_pad_in = (p2_pad.oe & p2_pad.out) | (~p2_pad.oe & ext_p2);
      // Open-drain pins only pull low; ext_p3 stands for the pull-ups
      p3_pad_in = (p3_pad.oe & p3_pad.out) | (~p3_pad.oe & ext_p3);
   end
endmodule // mio_pins_model

// ===== test_mio_port_unit.sv
// Self-checking testbench for the multiplexed port unit
`timescale 1ns/100ps
module test_mio_port_unit;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, serr;
   logic [7:0] gcs = 8'h3C, ext_p2 = 8'hFF, p1_pad_in, p2_pad_in;
   logic [5:0] ext_p3 = 6'h3F, p3_pad_in;
   logic tx0 = 1'b1, tx1 = 1'b0, rx0_out = 1'b0, rx0_oe = 1'b0, rx1_oe = 1'b0;
   logic s0_rx, s0_bclk, s0_cts, s1_rx, s1_bclk, s1_cts;
   mio_pkg::mio_pad8_t p1_pad, p2_pad;
   mio_pkg::mio_pad6_t p3_pad;
   int n_errors = 0;
   int checks_done = 0;

   always #25 pclk = ~pclk;

   mio_port_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .general_chip_selects(gcs),
      .dma0_irq_out(1'b0), .dma1_irq_out(1'b1), .serial1_tx_irq_out(1'b1),
      .serial1_rx_irq_out(1'b0), .serial0_transmit(tx0), .serial1_transmit(tx1),
      .serial0_receive_out(rx0_out), .serial0_receive_oe(rx0_oe),
      .serial1_receive_out(1'b0), .serial1_receive_oe(rx1_oe),
      .serial0_receive(s0_rx), .serial0_baud_clock_in(s0_bclk),
      .serial0_clear_to_send(s0_cts), .serial1_receive(s1_rx),
      .serial1_baud_clock_in(s1_bclk), .serial1_clear_to_send(s1_cts),
      .p1_pad_in(p1_pad_in), .p1_pad(p1_pad), .p2_pad_in(p2_pad_in), .p2_pad(p2_pad),
      .p3_pad_in(p3_pad_in), .p3_pad(p3_pad));

   mio_pins_model pins (.p1_pad(p1_pad), .p2_pad(p2_pad), .p3_pad(p3_pad),
      .ext_p2(ext_p2), .ext_p3(ext_p3), .p1_pad_in(p1_pad_in),
      .p2_pad_in(p2_pad_in), .p3_pad_in(p3_pad_in));

   task test_done;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; holds the request until pready is seen high, giving up after 20 cycles
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask

   task settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask

   task t_reset;
      rd(12'h000, 32'h0000_00FF);
      rd(12'h010, 32'h0000_00FF);
      rd(12'h020, 32'h0000_000F);
      rd(12'h004, 32'h0000_00FF);
      rd(12'h024, 32'h0000_003F);
      chk(32'({p1_pad.oe, p1_pad.out}), 32'h0000_FF3C);
      chk(32'({p2_pad.oe, p2_pad.out & 8'h22}), 32'h0000_2202);
      chk(32'({p3_pad.oe, p3_pad.out[3:0]}), 32'h0000_00FA);
      $display("test reset done");
   endtask

   task t_out_only;
      wr(12'h008, 32'h0000_0055);
      wr(12'h000, 32'h0000_00F0);
      wr(12'h004, 32'h0000_0000);
      settle;
      chk(32'({p1_pad.oe, p1_pad.out}), 32'h0000_FF35);
      rd(12'h004, 32'h0000_0000);
      rd(12'h008, 32'h0000_0055);
      $display("test output-only done");
   endtask

   task t_bidir;
      wr(12'h018, 32'h0000_00A5);
      wr(12'h014, 32'h0000_00C0);
      wr(12'h010, 32'h0000_000F);
      settle;
      chk(32'({p2_pad.oe, p2_pad.out & 8'h33}), 32'h0000_3222);
      @(posedge pclk);
      rx0_oe <= 1'b1;
      rx0_out <= 1'b1;
      settle;
      chk(32'({p2_pad.oe, p2_pad.out & 8'h33}), 32'h0000_3323);
      @(posedge pclk);
      rx0_oe <= 1'b0;
      pstrb <= 4'h0;
      wr(12'h018, 32'h0000_00FF);
      pstrb <= 4'hF;
      rd(12'h018, 32'h0000_00A5);
      $display("test bidirectional done");
   endtask

   task t_open_drain;
      wr(12'h028, 32'h0000_0010);
      wr(12'h024, 32'h0000_000F);
      wr(12'h020, 32'h0000_000F);
      settle;
      chk(32'({p3_pad.oe[5:4], p3_pad.out[5]}), 32'h0000_0004);
      rd(12'h02C, 32'h0000_001A);
      wr(12'h024, 32'h0000_003F);
      settle;
      chk(32'(p3_pad.oe), 32'h0000_000F);
      wr(12'h024, 32'h0000_000F);
      wr(12'h020, 32'h0000_003F);
      settle;
      chk(32'(p3_pad.oe), 32'h0000_000F);
      wr(12'h028, 32'hFFFF_FFFF);
      rd(12'h028, 32'h0000_003F);
      $display("test open-drain done");
   endtask

   task t_level;
      wr(12'h010, 32'h0000_00FF);
      ext_p2 <= 8'hD5;
      rx1_oe <= 1'b1;
      settle;
      rd(12'h01C, 32'h0000_00C7);
      chk(32'({s1_cts, s1_bclk, s1_rx, s0_bclk, s0_cts, s0_rx}), 32'h0000_0035);
      @(posedge pclk);
      ext_p2 <= 8'hDD;
      @(posedge pclk);
      #1;
      chk(32'(s0_cts), 32'h0000_0000);
      @(posedge pclk);
      #1;
      chk(32'(s0_cts), 32'h0000_0001);
      rd(12'h030, 32'h0000_0000);
      chk(32'(serr), 32'h0000_0001);
      $display("test pin level done");
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      t_reset;
      t_out_only;
      t_bidir;
      t_open_drain;
      t_level;
      test_done;
   end

   initial begin
      #200000;
      n_errors++;
      test_done;
   end
endmodule // test_mio_port_unit
